// File: pkg/rub_pkg.sv
package rub_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL_STATUS_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_STATUS_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_STATUS_C = 8'h08;
  localparam logic [7:0] OFS_DATA_BUFFER   = 8'h0c;

  // ctrl_status_a fields
  localparam int RX_DONE_POS  = 7;
  localparam int FRAMING_POS  = 4;
  localparam int OVERRUN_POS  = 3;
  localparam int PARITY_POS   = 2;
  // ctrl_status_b fields
  localparam int IRQ_EN_POS   = 7;
  localparam int RX_EN_POS    = 4;
  localparam int RX_NINTH_POS = 1;
  localparam int TX_NINTH_POS = 0;
  // ctrl_status_c fields
  localparam int PAR_EN_POS   = 5;
  localparam int PAR_ODD_POS  = 4;
  localparam int STOP_SEL_POS = 3;
  localparam int SIZE_LSB     = 0;
  localparam int SIZE_W       = 3;

  localparam logic [7:0] CTRL_STATUS_B_RST = 8'h00;
  localparam logic [7:0] CTRL_STATUS_C_RST = 8'h03;

  // character size codes and bit counts
  localparam logic [SIZE_W-1:0] SIZE_FIVE  = 3'h0;
  localparam logic [SIZE_W-1:0] SIZE_EIGHT = 3'h3;
  localparam logic [SIZE_W-1:0] SIZE_NINE  = 3'h7;
  localparam logic [3:0]        BITS_MIN   = 4'h5;
  localparam logic [3:0]        BITS_EIGHT = 4'h8;
  localparam logic [3:0]        BITS_NINE  = 4'h9;

  localparam int   HTRANS_ACT_POS = 1;
  localparam logic HRESP_OKAY     = 1'b0;

  typedef struct packed {
    logic       ninth;
    logic       framing;
    logic       overrun;
    logic       parity;
    logic [7:0] data;
  } rub_entry_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DATA = 5'b00010,
    ST_PAR  = 5'b00100,
    ST_STOP = 5'b01000,
    ST_HOLD = 5'b10000
  } rub_state_t;

endpackage

// File: hdl/rub_rx_fifo.sv
`timescale 1ns/1ps
module rub_rx_fifo
(
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              flush_i,
  input  wire logic              push_i,
  input  wire rub_pkg::rub_entry_t push_entry_i,
  input  wire logic              pop_i,
  output rub_pkg::rub_entry_t    head_o,
  output logic [1:0]             count_o,
  output logic                   full_o,
  output logic                   empty_o
);
  import rub_pkg::*;

  localparam logic [1:0] DEPTH = 2'h2;

  rub_entry_t mem_ff [2];
  logic       wr_ptr_ff;
  logic       rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic       do_push;
  logic       do_pop;

  assign empty_o = (cnt_ff == 2'h0);
  assign full_o  = (cnt_ff == DEPTH);
  assign count_o = cnt_ff;
  assign head_o  = mem_ff[rd_ptr_ff];
  assign do_pop  = pop_i & ~empty_o;
  // push while full is allowed when the same cycle frees a slot
  assign do_push = push_i & (~full_o | do_pop);

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end
    else if (flush_i)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end
    else
    begin
      if (do_push)
      begin
        mem_ff[wr_ptr_ff] <= push_entry_i;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (do_pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

endmodule

// File: hdl/rub_uart_rx.sv
// Function
// - every data read pops the buffer, exposing next frame's ninth bit and errors.
// - the slot just read is free for a new frame one cycle after the read.
// - receive-done flag is one exactly while unread frames are buffered.
// - clearing receiver enable flushes the buffer and drops receive-done.
// - receive-done interrupt requested as long as the flag and its enable are set.
// - framing, overrun, parity flags travel in the buffer with their frame.
// - writes to error flag positions do nothing.
// - error flags never raise an interrupt.
// - framing flag is one when the first stop bit sampled zero.
// - only the first stop bit is checked, whatever the stop bit count.
// - overrun when buffer full, frame waiting and new start bit; waiting frame lost.
// - overrun flag clears when a frame moves into the buffer.
// - parity checked only with parity enable set; odd-select picks the sense.
// - parity compares data bits with the parity bit, result stored with frame.
// - parity flag zero unless checking was on; valid until data read.
// - disabling receiver is immediate, aborts reception, releases the pin.
// - after the first stop bit the frame moves into the buffer.
// - unused upper data bits read as zero for short characters.
// - stop bit voted like others; a zero stop bit marks a framing error.
`timescale 1ns/1ps
module rub_uart_rx
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        start_det_i,
  input  wire logic        bit_valid_i,
  input  wire logic        bit_value_i,
  output logic             rx_pin_claim_o,
  output logic             tx_ninth_bit_o,
  output logic             rx_done_irq_o
);
  import rub_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // bus slave
  logic       ap_valid;
  logic       ap_rd;
  logic       ap_rd_data;
  logic [7:0] ap_addr;
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] rd_val;
  logic [31:0] hrdata_ff;

  // registers
  logic       irq_en_ff;
  logic       rx_en_ff;
  logic       tx_ninth_ff;
  logic       par_en_ff;
  logic       par_odd_ff;
  logic       stop_sel_ff;
  logic [SIZE_W-1:0] size_ff;
  logic       wr_b;
  logic       wr_c;

  // receiver
  rub_state_t state_ff;
  rub_state_t nxt_state;
  logic [8:0] shift_ff;
  logic [8:0] nxt_shift;
  logic [3:0] bitcnt_ff;
  logic [3:0] nxt_bitcnt;
  logic       par_bit_ff;
  logic       nxt_par_bit;
  logic       ovr_pend_ff;
  logic       nxt_ovr_pend;
  rub_entry_t hold_ff;
  rub_entry_t nxt_hold;
  logic [3:0] nbits;
  logic       last_data;
  rub_entry_t stop_entry;
  rub_entry_t push_entry;
  logic       push;
  logic       overrun_evt;

  // buffer
  rub_entry_t head;
  logic [1:0] fifo_cnt;
  logic       fifo_full;
  logic       fifo_empty;
  logic       rx_done;
  logic [7:0] data_mask;

  assign ap_valid   = hsel_i & htrans_i[HTRANS_ACT_POS] & hready_i;
  assign ap_addr    = haddr_i[7:0];
  assign ap_rd      = ap_valid & ~hwrite_i;
  assign ap_rd_data = ap_rd & (ap_addr == OFS_DATA_BUFFER);
  assign wr_b       = wr_pend_ff & (wr_addr_ff == OFS_CTRL_STATUS_B);
  assign wr_c       = wr_pend_ff & (wr_addr_ff == OFS_CTRL_STATUS_C);

  // zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = hrdata_ff;

  assign rx_done        = ~fifo_empty;
  assign rx_done_irq_o  = irq_en_ff & rx_done;
  assign rx_pin_claim_o = rx_en_ff;
  assign tx_ninth_bit_o = tx_ninth_ff;

  assign nbits = (size_ff == SIZE_NINE) ? BITS_NINE :
                 (size_ff <= SIZE_EIGHT) ? BITS_MIN + {1'b0, size_ff} : BITS_EIGHT;
  assign last_data = (bitcnt_ff == nbits - 4'h1);
  assign data_mask = (nbits >= BITS_EIGHT) ? 8'hff : 8'((9'h001 << nbits) - 9'h001);

  // read mux, sampled in the address phase; an immediately preceding write
  // to the same register is not yet visible
  always_comb
  begin
    rd_val = 8'h00;
    if (ap_addr == OFS_CTRL_STATUS_A)
    begin
      rd_val[RX_DONE_POS] = rx_done;
      rd_val[FRAMING_POS] = rx_done & head.framing;
      rd_val[OVERRUN_POS] = rx_done & head.overrun;
      rd_val[PARITY_POS]  = rx_done & head.parity;
    end
    else if (ap_addr == OFS_CTRL_STATUS_B)
    begin
      rd_val[IRQ_EN_POS]   = irq_en_ff;
      rd_val[RX_EN_POS]    = rx_en_ff;
      rd_val[RX_NINTH_POS] = rx_done & head.ninth;
      rd_val[TX_NINTH_POS] = tx_ninth_ff;
    end
    else if (ap_addr == OFS_CTRL_STATUS_C)
    begin
      rd_val[PAR_EN_POS]                   = par_en_ff;
      rd_val[PAR_ODD_POS]                  = par_odd_ff;
      rd_val[STOP_SEL_POS]                 = stop_sel_ff;
      rd_val[SIZE_LSB +: SIZE_W]           = size_ff;
    end
    else if (ap_addr == OFS_DATA_BUFFER)
      rd_val = rx_done ? (head.data & data_mask) : 8'h00;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= ap_valid & hwrite_i;
      wr_addr_ff <= ap_addr;
      if (ap_rd)
        hrdata_ff <= {24'h00_0000, rd_val};
    end
  end

  // ctrl_status_a is all read-only: its error positions ignore writes
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_en_ff   <= CTRL_STATUS_B_RST[IRQ_EN_POS];
      rx_en_ff    <= CTRL_STATUS_B_RST[RX_EN_POS];
      tx_ninth_ff <= CTRL_STATUS_B_RST[TX_NINTH_POS];
      par_en_ff   <= CTRL_STATUS_C_RST[PAR_EN_POS];
      par_odd_ff  <= CTRL_STATUS_C_RST[PAR_ODD_POS];
      stop_sel_ff <= CTRL_STATUS_C_RST[STOP_SEL_POS];
      size_ff     <= CTRL_STATUS_C_RST[SIZE_LSB +: SIZE_W];
    end
    else
    begin
      if (wr_b)
      begin
        irq_en_ff   <= hwdata_i[IRQ_EN_POS];
        rx_en_ff    <= hwdata_i[RX_EN_POS];
        tx_ninth_ff <= hwdata_i[TX_NINTH_POS];
      end
      if (wr_c)
      begin
        par_en_ff   <= hwdata_i[PAR_EN_POS];
        par_odd_ff  <= hwdata_i[PAR_ODD_POS];
        stop_sel_ff <= hwdata_i[STOP_SEL_POS];
        size_ff     <= hwdata_i[SIZE_LSB +: SIZE_W];
      end
    end
  end

  // frame as it stands at the first stop bit; later stop bits never reach here
  always_comb
  begin
    stop_entry         = '0;
    stop_entry.data    = shift_ff[7:0];
    stop_entry.ninth   = shift_ff[8];
    stop_entry.framing = ~bit_value_i;
    stop_entry.overrun = ovr_pend_ff;
    stop_entry.parity  = par_en_ff & (^shift_ff ^ par_bit_ff ^ par_odd_ff);
  end

  assign push       = rx_en_ff & ~fifo_full &
                      (((state_ff == ST_STOP) & bit_valid_i) | (state_ff == ST_HOLD));
  assign push_entry = (state_ff == ST_HOLD) ? hold_ff : stop_entry;
  assign overrun_evt = (state_ff == ST_HOLD) & fifo_full & start_det_i;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_shift    = shift_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_par_bit  = par_bit_ff;
    nxt_hold     = hold_ff;
    nxt_ovr_pend = ovr_pend_ff;
    if (push)
      nxt_ovr_pend = 1'b0;
    case (state_ff)
      ST_IDLE:
        if (start_det_i)
        begin
          nxt_state  = ST_DATA;
          nxt_shift  = 9'h000;
          nxt_bitcnt = 4'h0;
        end
      ST_DATA:
        if (bit_valid_i)
        begin
          nxt_shift[bitcnt_ff] = bit_value_i;
          nxt_bitcnt           = bitcnt_ff + 4'h1;
          if (last_data)
            nxt_state = par_en_ff ? ST_PAR : ST_STOP;
        end
      ST_PAR:
        if (bit_valid_i)
        begin
          nxt_par_bit = bit_value_i;
          nxt_state   = ST_STOP;
        end
      ST_STOP:
        if (bit_valid_i)
        begin
          nxt_hold  = stop_entry;
          nxt_state = fifo_full ? ST_HOLD : ST_IDLE;
        end
      ST_HOLD:
        if (start_det_i)
        begin
          // the waiting frame is dropped when no slot freed in time
          if (overrun_evt)
            nxt_ovr_pend = 1'b1;
          nxt_state  = ST_DATA;
          nxt_shift  = 9'h000;
          nxt_bitcnt = 4'h0;
        end
        else if (!fifo_full)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!rx_en_ff)
    begin
      nxt_state    = ST_IDLE;
      nxt_ovr_pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff    <= ST_IDLE;
      shift_ff    <= 9'h000;
      bitcnt_ff   <= 4'h0;
      par_bit_ff  <= 1'b0;
      hold_ff     <= '0;
      ovr_pend_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      shift_ff    <= nxt_shift;
      bitcnt_ff   <= nxt_bitcnt;
      par_bit_ff  <= nxt_par_bit;
      hold_ff     <= nxt_hold;
      ovr_pend_ff <= nxt_ovr_pend;
    end
  end

  rub_rx_fifo u_fifo
  (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .flush_i      (~rx_en_ff),
    .push_i       (push),
    .push_entry_i (push_entry),
    .pop_i        (ap_rd_data),
    .head_o       (head),
    .count_o      (fifo_cnt),
    .full_o       (fifo_full),
    .empty_o      (fifo_empty)
  );

  a_pop_advances: assert property (
    (rx_en_ff && ap_rd_data && !fifo_empty && !push) |=> (fifo_cnt == $past(fifo_cnt) - 2'h1))
    else $error("data read did not advance the buffer");

  a_flush_empties: assert property (
    (!rx_en_ff) |=> (!rx_done && (fifo_cnt == 2'h0)))
    else $error("disabled receiver left frames buffered");

  a_irq_tracks_flag: assert property (
    (irq_en_ff && rx_done && !ap_rd_data && rx_en_ff && !wr_b) |=> rx_done_irq_o)
    else $error("interrupt request dropped while flag set");

  a_err_no_irq: assert property (
    (rx_done_irq_o) |-> (irq_en_ff && fifo_cnt != 2'h0))
    else $error("interrupt without receive-done");

  a_err_write_ignored: assert property (
    (wr_pend_ff && wr_addr_ff == OFS_CTRL_STATUS_A && !push && !ap_rd_data && rx_en_ff) |=> $stable(head))
    else $error("status write altered error flags");

  a_stop_moves: assert property (
    (rx_en_ff && state_ff == ST_STOP && bit_valid_i && !fifo_full && !ap_rd_data)
      |=> (fifo_cnt == $past(fifo_cnt) + 2'h1))
    else $error("completed frame not moved into buffer");

  a_overrun_set: assert property (
    (rx_en_ff && overrun_evt) |=> (ovr_pend_ff && state_ff == ST_DATA))
    else $error("overrun not recorded");

  a_overrun_clear: assert property (
    (push && rx_en_ff) |=> !ovr_pend_ff)
    else $error("overrun not cleared on transfer");

  a_parity_off_zero: assert property (
    (push && state_ff == ST_STOP && !par_en_ff) |-> !push_entry.parity)
    else $error("parity error stored with checking off");

  a_upper_zero: assert property (
    (ap_rd_data && size_ff == SIZE_FIVE) |=> (hrdata_o[7:5] == 3'h0))
    else $error("unused data bits not zero");

  a_rx_release: assert property (
    (!rx_en_ff && !wr_b) |=> (state_ff == ST_IDLE) && !rx_pin_claim_o)
    else $error("receiver still active after disable");

endmodule

// File: dv/rub_serial_src.sv
`timescale 1ns/1ps
module rub_serial_src
(
  input  wire logic ref_clk_i,
  output logic      start_det_o,
  output logic      bit_valid_o,
  output logic      bit_value_o
);
  // idle cycles between bits beyond the one always there; nonzero makes a slow sender
  int gap = 0;

  initial
  begin
    start_det_o = 1'b0;
    bit_valid_o = 1'b0;
    bit_value_o = 1'b1;
  end

  task automatic pulse(input logic st, input logic v);
    @(posedge ref_clk_i);
    start_det_o <= st;
    bit_valid_o <= !st;
    bit_value_o <= v;
    @(posedge ref_clk_i);
    start_det_o <= 1'b0;
    bit_valid_o <= 1'b0;
    // unqualified line shows the inverse, never a stale value
    bit_value_o <= !v;
    repeat (gap) @(posedge ref_clk_i);
  endtask

  task automatic bits(input logic [8:0] d, input int n);
    for (int i = 0; i < n; i++)
      pulse(1'b0, d[i]);
  endtask

  task automatic frame(input logic [8:0] d, input int n, input logic pe,
                       input logic pb, input logic stp);
    pulse(1'b1, 1'b0);
    bits(d, n);
    if (pe)
      pulse(1'b0, pb);
    // only the first stop bit is ever sent
    pulse(1'b0, stp);
  endtask
endmodule

// File: dv/uart_receive_buffer_status_tb.sv
`timescale 1ns/1ps
module uart_receive_buffer_status_tb;
  import rub_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [31:0] hrdata_o;
  logic        start_det;
  logic        bit_valid;
  logic        bit_value;
  logic        rx_pin_claim_o;
  logic        tx_ninth_bit_o;
  logic        rx_done_irq_o;
  logic        rd_dph = 1'b0;
  logic [31:0] seed = 32'h30a5;
  logic [8:0]  d [4];
  logic [31:0] e;
  logic [3:0]  nb;
  logic        pb;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [31:0] exp_q [$];
  string       nm_q [$];

  initial
  begin
    forever #4 ref_clk_i = !ref_clk_i;
  end

  rub_uart_rx rub_uart_rx_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .start_det_i(start_det), .bit_valid_i(bit_valid), .bit_value_i(bit_value),
    .rx_pin_claim_o(rx_pin_claim_o), .tx_ninth_bit_o(tx_ninth_bit_o),
    .rx_done_irq_o(rx_done_irq_o));

  rub_serial_src rub_serial_src_inst (.ref_clk_i(ref_clk_i), .start_det_o(start_det),
    .bit_valid_o(bit_valid), .bit_value_o(bit_value));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (hreadyout_o !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      bad_count++;
      end_of_test();
    end
  endtask

  // reads note their expectation; the monitor below compares
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input string nm);
    if (!w)
    begin
      exp_q.push_back(v);
      nm_q.push_back(nm);
    end
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= w ? v : 32'h0;
    wait_rdy();
  endtask

  always @(posedge ref_clk_i)
  begin
    if (rd_dph && hreadyout_o === 1'b1 && exp_q.size() > 0)
    begin
      check(nm_q.pop_front(), exp_q.pop_front(), hrdata_o);
      check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp_o});
    end
    rd_dph <= hsel_i && htrans_i[1] && hreadyout_o && !hwrite_i;
  end

  initial
  begin
    repeat (50000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    bus(0, OFS_CTRL_STATUS_B, {24'h0, CTRL_STATUS_B_RST}, "rst_b");
    bus(0, OFS_CTRL_STATUS_C, {24'h0, CTRL_STATUS_C_RST}, "rst_c");
    bus(0, OFS_CTRL_STATUS_A, 32'h0, "rst_a");
    bus(0, 8'h10, 32'h0, "unmapped");
    bus(1, OFS_CTRL_STATUS_B, 32'h10, "");
    @(negedge ref_clk_i);
    check("pin_claim", 32'h1, {31'h0, rx_pin_claim_o});
    for (int i = 0; i < 4; i++)
    begin
      e = rnd();
      d[i] = {1'b0, e[7:0]};
    end
    rub_serial_src_inst.frame(d[0], 8, 0, 0, 0);
    rub_serial_src_inst.frame(d[1], 8, 0, 0, 1);
    // third frame waits in hold_ff, the next start loses it
    rub_serial_src_inst.frame(d[2], 8, 0, 0, 1);
    rub_serial_src_inst.frame(d[3], 8, 0, 0, 1);
    @(negedge ref_clk_i);
    check("err_irq", 32'h0, {31'h0, rx_done_irq_o});
    bus(1, OFS_CTRL_STATUS_A, 32'h0, "");
    bus(0, OFS_CTRL_STATUS_A, 32'h90, "fe_head");
    bus(0, OFS_DATA_BUFFER, {24'h0, d[0][7:0]}, "d0");
    bus(0, OFS_CTRL_STATUS_A, 32'h80, "d1_stat");
    bus(0, OFS_DATA_BUFFER, {24'h0, d[1][7:0]}, "d1");
    bus(0, OFS_CTRL_STATUS_A, 32'h88, "ovr");
    bus(0, OFS_DATA_BUFFER, {24'h0, d[3][7:0]}, "d3");
    bus(0, OFS_CTRL_STATUS_A, 32'h0, "empty");
    bus(1, OFS_CTRL_STATUS_B, 32'h91, "");
    rub_serial_src_inst.frame(d[2], 8, 0, 0, 1);
    @(negedge ref_clk_i);
    check("irq_on", 32'h1, {31'h0, rx_done_irq_o});
    check("tx_ninth", 32'h1, {31'h0, tx_ninth_bit_o});
    bus(0, OFS_CTRL_STATUS_A, 32'h80, "ovr_clr");
    bus(0, OFS_DATA_BUFFER, {24'h0, d[2][7:0]}, "d2");
    @(negedge ref_clk_i);
    check("irq_off", 32'h0, {31'h0, rx_done_irq_o});
    rub_serial_src_inst.gap = 3;
    for (int k = 0; k < 4; k++)
    begin
      bus(1, OFS_CTRL_STATUS_C, 32'h23 | (k[0] << 4), "");
      e = rnd();
      d[0] = {1'b0, e[7:0]};
      pb = ^d[0][7:0] ^ k[0] ^ k[1];
      rub_serial_src_inst.frame(d[0], 8, 1, pb, 1);
      bus(0, OFS_CTRL_STATUS_A, 32'h80 | (k[1] << 2), "par");
      bus(0, OFS_DATA_BUFFER, {24'h0, d[0][7:0]}, "par_d");
    end
    rub_serial_src_inst.gap = 0;
    for (int i = 0; i < 5; i++)
    begin
      nb = (i == 4) ? BITS_NINE : BITS_MIN + 4'(i);
      e = (i == 4) ? {29'h0, SIZE_NINE} : {29'h0, 3'(i)};
      bus(1, OFS_CTRL_STATUS_C, e | (i[0] << 3), "");
      e = rnd();
      d[0] = e[8:0];
      rub_serial_src_inst.frame(d[0], nb, 0, 0, i[1]);
      bus(0, OFS_CTRL_STATUS_A, 32'h80 | (32'(!i[1]) << 4), "stop");
      if (i == 4)
        bus(0, OFS_CTRL_STATUS_B, 32'h91 | (d[0][8] << 1), "ninth");
      e = d[0] & ((32'h1 << nb) - 1) & 32'hff;
      bus(0, OFS_DATA_BUFFER, e, "size_d");
    end
    bus(1, OFS_CTRL_STATUS_C, 32'h3, "");
    rub_serial_src_inst.frame(d[1], 8, 0, 0, 1);
    rub_serial_src_inst.frame(d[2], 8, 0, 0, 1);
    bus(1, OFS_CTRL_STATUS_B, 32'h0, "");
    @(negedge ref_clk_i);
    check("flush_irq", 32'h0, {31'h0, rx_done_irq_o});
    check("release", 32'h0, {31'h0, rx_pin_claim_o});
    rub_serial_src_inst.frame(d[1], 8, 0, 0, 1);
    bus(0, OFS_CTRL_STATUS_A, 32'h0, "flushed");
    bus(1, OFS_CTRL_STATUS_B, 32'h10, "");
    rub_serial_src_inst.pulse(1, 0);
    rub_serial_src_inst.bits(9'h1a5, 3);
    bus(1, OFS_CTRL_STATUS_B, 32'h0, "");
    bus(1, OFS_CTRL_STATUS_B, 32'h10, "");
    rub_serial_src_inst.frame(d[3], 8, 0, 0, 1);
    bus(0, OFS_CTRL_STATUS_A, 32'h80, "abort");
    bus(0, OFS_DATA_BUFFER, {24'h0, d[3][7:0]}, "abort_d");
    repeat (2) @(posedge ref_clk_i);
    end_of_test();
  end
endmodule
